//--- include/lpss_pkg.sv
// Constants and carrier types for the panel power-save sequencer
//
// Overview of operation
// (R1) Hardware input low or unconfigured: decode two software bits, 00 save, 11 normal.
// (R2) Hardware save input configured and high forces hardware power save.
// (R3) Software save stops refresh, powers panel down, keeps register and memory access.
// (R4) Colour lookup table access allowed only in normal operation.
// (R5) Hardware save disables the whole host bus interface.
// (R6) Power save halts sequencer, stops display, holds panel power inactive; the code keeps power active for the FRAMES-frame ST_DN_WAIT delay first.
// (R7) Power save drives panel data, shift, line, frame and data-valid low.
// (R8) Upper four data pins assigned to general I/O are not forced low.
// (R9) After reset panel power inactive and panel outputs low until power-up.
// (R10) Writing 11b to bits 1:0 of register 03h starts power-up.
// (R11) Wait 127 frames between panel power step and signal step.
// (R12) Host programs registers first, lookup table only after bits set to 11b.
// (R13) Power-down on entering software save, power-up on leaving it.
// (R14) Host stops bus clock low and glitch free.
// (R15) Host keeps bus clock eight bus plus twelve memory clocks after access.
// (R16) Host restarts bus clock one period before next access.
// (R17) Memory access needs bus and input clock; registers need only bus clock.
// (R18) In software save host keeps bus clock; input clock stops after 128 frames.
// (R19) In hardware save bus clock optional; input clock stops after 128 frames.
// (R20) Reserved software codes act as power save, outputs low, refresh stopped.
package lpss_pkg;
	localparam logic [7:0] LPSS_REG_PWR = 8'h03;
	localparam logic [7:0] LPSS_REG_STAT = 8'h04;
	localparam logic [7:0] LPSS_REG_GPIO = 8'h05;
	localparam logic [1:0] LPSS_SW_SAVE = 2'h0;
	localparam logic [1:0] LPSS_SW_NORMAL = 2'h3;
	localparam logic [1:0] LPSS_PWR_RST = 2'h0;
	localparam int LPSS_SEQ_FRAMES = 127;
	localparam int LPSS_DATA_W = 12;
	localparam int LPSS_GPIO_LO = 8;
	typedef enum logic [1:0] {
		LPSS_MODE_NORMAL,
		LPSS_MODE_SW_SAVE,
		LPSS_MODE_HW_SAVE
	} lpss_mode_t;
	typedef struct packed {
		logic [11:0] data;
		logic shift;
		logic line;
		logic frame;
		logic valid;
	} lpss_panel_t;
endpackage : lpss_pkg

//--- hdl/lpss_sequencer.sv
// Panel power-save mode selection, access gating and power sequencing
//
// Strobed register access and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module lpss_sequencer
	import lpss_pkg::*;
#(
	parameter int FRAMES = LPSS_SEQ_FRAMES
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_hw_save_cfg,
	input wire logic i_hw_save,
	input wire logic i_frame_tick,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_lut_sel,
	input wire logic i_mem_sel,
	input wire logic i_reg_sel,
	output logic o_lut_ok,
	output logic o_mem_ok,
	output logic o_reg_ok,
	output logic o_refresh_en,
	output logic o_seq_run,
	input wire lpss_panel_t i_panel,
	output lpss_panel_t o_panel,
	output logic o_panel_power_enable
);
	typedef enum logic [2:0] {
		ST_OFF, ST_PWR_WAIT, ST_ON, ST_DN_WAIT
	} lpss_seq_t;

	logic hw_s1_r, hw_s2_r, tk_s1_r, tk_s2_r, tk_d_r;
	logic [1:0] pwr_r;
	logic gpio_r;
	logic [7:0] rdata_r;
	lpss_seq_t st_r;
	logic [7:0] cnt_r;
	lpss_mode_t mode;
	logic normal, tick, bus_en;
	lpss_panel_t pan_r;
	logic pwr_en_r;

	// Pins are asynchronous to i_clk
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			hw_s1_r <= 1'b0;
			hw_s2_r <= 1'b0;
			tk_s1_r <= 1'b0;
			tk_s2_r <= 1'b0;
			tk_d_r <= 1'b0;
		end else begin
			hw_s1_r <= i_hw_save;
			hw_s2_r <= hw_s1_r;
			tk_s1_r <= i_frame_tick;
			tk_s2_r <= tk_s1_r;
			tk_d_r <= tk_s2_r;
		end
	end
	assign tick = tk_s2_r & ~tk_d_r;

	always_comb begin
		if (i_hw_save_cfg && hw_s2_r)
			mode = LPSS_MODE_HW_SAVE; // [R2]
		else if (pwr_r == LPSS_SW_NORMAL)
			mode = LPSS_MODE_NORMAL; // [R1]
		else
			mode = LPSS_MODE_SW_SAVE; // Reserved codes save too [R20] [R1]
	end
	assign normal = (mode == LPSS_MODE_NORMAL);
	assign bus_en = (mode != LPSS_MODE_HW_SAVE); // [R5]

	// Register and memory ports stay up in software save [R3] [R17]
	assign o_reg_ok = i_reg_sel & bus_en; // [R5]
	assign o_mem_ok = i_mem_sel & bus_en; // [R5] [R3]
	assign o_lut_ok = i_lut_sel & normal; // [R4] [R12]

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pwr_r <= LPSS_PWR_RST; // [R9]
			gpio_r <= 1'b0;
		end else if (i_wr && bus_en) begin
			if (i_addr == LPSS_REG_PWR)
				pwr_r <= i_wdata[1:0]; // [R10]
			if (i_addr == LPSS_REG_GPIO)
				gpio_r <= i_wdata[0];
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn)
			rdata_r <= 8'h00;
		else if (i_rd && bus_en) begin
			case (i_addr)
				LPSS_REG_PWR: rdata_r <= {6'h00, pwr_r};
				LPSS_REG_STAT: rdata_r <= {3'h0, pwr_en_r, 1'b0, st_r};
				LPSS_REG_GPIO: rdata_r <= {7'h00, gpio_r};
				default: rdata_r <= 8'h00;
			endcase
		end else
			rdata_r <= 8'h00;
	end
	assign o_rdata = rdata_r;

	// Power enable leads signals on power-up and trails them on power-down
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_r <= ST_OFF;
			cnt_r <= 8'h00;
		end else begin
			case (st_r)
				ST_OFF: if (normal) begin // [R10] [R13]
					st_r <= ST_PWR_WAIT;
					cnt_r <= 8'h00;
				end
				ST_PWR_WAIT: if (!normal) st_r <= ST_OFF; // [R6]
					else if (tick) begin
						if (cnt_r == 8'(FRAMES - 1)) // [R11]
							st_r <= ST_ON;
						cnt_r <= cnt_r + 8'h01;
					end
				ST_ON: if (!normal) begin // [R13]
					st_r <= ST_DN_WAIT;
					cnt_r <= 8'h00;
				end
				// Panel still powered, so a return to normal re-waits signals
				ST_DN_WAIT: if (normal) begin // [R13]
					st_r <= ST_PWR_WAIT;
					cnt_r <= 8'h00;
				end else if (tick) begin
					if (cnt_r == 8'(FRAMES - 1)) // [R11]
						st_r <= ST_OFF;
					cnt_r <= cnt_r + 8'h01;
				end
				default: st_r <= ST_OFF;
			endcase
		end
	end

	assign o_seq_run = normal; // [R6]
	assign o_refresh_en = normal; // [R3] [R6]

	// Panel outputs registered; forced low except in normal operation with the sequence in ST_ON, upper four data bits follow i_panel when gpio_r is set
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pan_r <= '0; // [R9]
			pwr_en_r <= 1'b0; // [R9]
		end else begin
			// Power trails the signals by the sequence delay on the way down
			pwr_en_r <= (st_r == ST_ON) || (st_r == ST_DN_WAIT) ||
				(normal && st_r == ST_PWR_WAIT); // [R6] [R11] [R13]
			if (normal && st_r == ST_ON)
				pan_r <= i_panel;
			else begin
				pan_r <= '0; // [R7]
				if (gpio_r) // [R8]
					pan_r.data[LPSS_DATA_W-1:LPSS_GPIO_LO] <=
						i_panel.data[LPSS_DATA_W-1:LPSS_GPIO_LO];
			end
		end
	end
	assign o_panel = pan_r;
	assign o_panel_power_enable = pwr_en_r;
endmodule : lpss_sequencer
`default_nettype wire

//--- verification/lpss_far.sv
// Frame clock source standing in for the panel timing side
`timescale 1ns/1ps
`default_nettype none
module lpss_far (
	input wire logic i_run,
	output logic o_tick
);
	initial o_tick = 1'b0;
	// Free running while enabled; the host may stop it only in save
	always #400 if (i_run) o_tick = ~o_tick;
endmodule : lpss_far
`default_nettype wire

//--- verification/lpss_sequencer_chk.sv
// Port assertions for the power-save sequencer
`timescale 1ns/1ps
`default_nettype none
module lpss_chk
	import lpss_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_hw_save_cfg,
	input wire logic i_hw_save,
	input wire logic i_lut_sel,
	input wire logic i_reg_sel,
	input wire logic o_lut_ok,
	input wire logic o_mem_ok,
	input wire logic o_reg_ok,
	input wire logic o_refresh_en,
	input wire logic o_seq_run,
	input wire lpss_panel_t o_panel,
	input wire logic o_panel_power_enable
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// Four cycles of slack cover the pin synchroniser
	wire logic hw = i_hw_save_cfg && i_hw_save;
	lut_gate_a: assert property (o_lut_ok |-> i_lut_sel && o_seq_run)
		else $error("lut grant outside normal");
	hw_bus_a: assert property (hw[*4] |-> !o_reg_ok && !o_mem_ok)
		else $error("bus open in hw save");
	hw_stop_a: assert property (hw[*4] |-> !o_seq_run)
		else $error("running in hw save");
	sw_reg_a: assert property ((!hw)[*4] ##0 i_reg_sel |-> o_reg_ok)
		else $error("register access refused");
	stop_ref_a: assert property (!o_seq_run |-> !o_refresh_en)
		else $error("refresh in save");
	out_low_a: assert property ((!o_seq_run)[*2] |-> o_panel[11:0] == 0)
		else $error("panel not low in save");
	pwr_up_a: assert property ($rose(o_panel_power_enable) |->
		o_seq_run && o_panel[11:0] == 0) else $error("bad power up");
	pwr_dn_a: assert property ($fell(o_panel_power_enable) |-> !o_seq_run)
		else $error("power off while normal");
endmodule : lpss_chk
bind lpss_sequencer lpss_chk u_chk (.i_clk, .i_rstn, .i_hw_save_cfg,
	.i_hw_save, .i_lut_sel, .i_reg_sel, .o_lut_ok, .o_mem_ok, .o_reg_ok,
	.o_refresh_en, .o_seq_run, .o_panel, .o_panel_power_enable);
`default_nettype wire

//--- verification/lpss_sequencer_test.sv
// Self-checking bench for the power-save sequencer
`timescale 1ns/1ps
`default_nettype none
module lpss_sequencer_test;
	import lpss_pkg::*;
	logic i_clk = 0, i_rstn = 0, i_hw_save_cfg = 1, i_hw_save = 0;
	logic i_wr = 0, i_rd = 0, i_lut_sel = 1, i_mem_sel = 1, i_reg_sel = 1;
	logic [7:0] i_addr = 0, i_wdata = 0, o_rdata;
	logic o_lut_ok, o_mem_ok, o_reg_ok, o_refresh_en, o_seq_run;
	logic o_panel_power_enable;
	lpss_panel_t i_panel = '0, o_panel;
	wire logic i_frame_tick;
	wire logic [3:0] grants = {o_lut_ok, o_mem_ok, o_reg_ok, o_seq_run};
	logic [31:0] rs = 32'h0000_0023;
	int err_total = 0, checked = 0;
	lpss_sequencer #(.FRAMES(3)) DUT (.i_clk, .i_rstn, .i_hw_save_cfg,
		.i_hw_save, .i_frame_tick, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_lut_sel, .i_mem_sel, .i_reg_sel, .o_lut_ok, .o_mem_ok, .o_reg_ok,
		.o_refresh_en, .o_seq_run, .i_panel, .o_panel, .o_panel_power_enable);
	lpss_far u_far (.i_run(1'b1), .o_tick(i_frame_tick));
	initial forever #50 i_clk = ~i_clk;
	// Grants expected with every select held high: lut, mem, reg, run
	function automatic logic [3:0] mdl(int b, int h);
		return h ? 4'h0 : (b == 3 ? 4'hf : 4'h6);
	endfunction : mdl
	function automatic logic [31:0] xs(logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction : xs
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask : chk
	// Bus clock never stopped, strobes one cycle
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1;
		@(posedge i_clk);
		i_wr <= 0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1;
		@(posedge i_clk);
		i_rd <= 0;
		#1 chk("rdata", o_rdata, e);
	endtask : rd
	task end_sim;
		if (err_total == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_sim
	initial begin
		#200000;
		err_total++;
		end_sim();
	end
	initial begin
		int q[$] = '{1, 2, 0};
		repeat (6) @(posedge i_clk);
		i_rstn <= 1;
		@(posedge i_clk);
		#1 chk("power", o_panel_power_enable, 0);
		chk("panel", o_panel, 0);
		chk("grants", grants, mdl(0, 0));
		rs = xs(rs);
		i_panel <= lpss_panel_t'(rs[15:0]);
		wr(LPSS_REG_PWR, 8'h03); // Lookup table only after this
		#1 chk("grants", grants, mdl(3, 0));
		repeat (2) @(posedge i_frame_tick);
		#1 chk("power", o_panel_power_enable, 1);
		chk("panel", o_panel, 0);
		repeat (3) @(posedge i_frame_tick);
		@(posedge i_clk);
		#1 chk("panel", o_panel, i_panel);
		foreach (q[k]) begin
			wr(LPSS_REG_PWR, 8'(q[k]));
			@(posedge i_clk);
			#1 chk("grants", grants, mdl(q[k], 0));
			chk("panel", o_panel, 0);
			if (k == 0) chk("power", o_panel_power_enable, 1);
			rd(LPSS_REG_PWR, 8'(q[k]));
		end
		rd(8'h0f, 8'h00);
		wr(LPSS_REG_GPIO, 8'h01);
		@(posedge i_clk);
		#1 chk("panel", o_panel, {i_panel[15:12], 12'h000});
		i_hw_save <= 1;
		repeat (4) @(posedge i_clk);
		#1 chk("grants", grants, mdl(0, 1));
		rd(LPSS_REG_PWR, 8'h00);
		wr(LPSS_REG_PWR, 8'h03);
		i_hw_save <= 0;
		repeat (4) @(posedge i_clk);
		#1 chk("grants", grants, mdl(0, 0));
		repeat (4) @(posedge i_frame_tick);
		@(posedge i_clk);
		#1 chk("power", o_panel_power_enable, 0);
		i_hw_save_cfg <= 0;
		i_hw_save <= 1;
		repeat (4) @(posedge i_clk);
		#1 chk("grants", grants, mdl(0, 0));
		end_sim();
	end
endmodule : lpss_sequencer_test
`default_nettype wire
